// >>> hcir_regs.sv
`timescale 1ns/1ns
`include "hcir_map.svh"
module hcir_regs
(
    input  wire logic                    i_clk,
    input  wire logic                    i_sys_rst,
    input  wire hcir_pkg::hcir_bus_req_t i_bus,
    output logic [31:0]                  o_rdata,
    output logic                         o_synth_sclk,
    output logic                         o_synth_sdata,
    output logic [3:0]                   o_synth_load,
    output hcir_pkg::hcir_flash_pins_t   o_flash,
    input  wire logic [7:0]              i_flash_dq,
    input  wire logic                    i_flash_jumper,
    output logic                         o_fpga_program_pin,
    output logic                         o_fpga_init_drive,
    input  wire logic                    i_fpga_init_pin,
    input  wire logic                    i_fpga_done_pin,
    output logic                         o_cfg_clk,
    output logic                         o_cfg_bit,
    output logic [6:0]                   o_user_reg_index,
    output logic                         o_burst_fifo_enable,
    input  wire logic                    i_user_fpga_irq,
    input  wire logic                    i_sg_done,
    input  wire logic                    i_sg_complete_irq_enable,
    input  wire logic                    i_page_irq,
    output logic                         o_host_irq
);
    import hcir_pkg::*;

    // ------------------------------------------------------------------
    // Decoding helpers.
    // ------------------------------------------------------------------

    // True when the address selects the given register.
    function automatic logic hit(input logic [7:0] a,
                                 input logic [7:0] off);
        hit = (a == off);
    endfunction

    // ------------------------------------------------------------------
    // Declarations.
    // ------------------------------------------------------------------
    logic [7:0]  synth_q, synth_d;
    logic [31:0] faddr_q, faddr_d;
    logic [7:0]  fdata_q, fdata_d;
    logic [31:0] cfg_q, cfg_d;
    logic        pend_q, pend_d;
    logic        cclk_q, cclk_d;
    logic        host_irq_q, host_irq_d;
    logic [31:0] rdata_q, rdata_d;
    logic [3:0]  sync1_q, sync2_q;
    logic        jumper_s, init_s, done_s, user_s;
    logic        wr_synth, wr_faddr, wr_fdata, wr_cfg;
    logic        rd_cfg, rd_stat;
    logic        fl_busy, fl_done, fl_start;
    logic [7:0]  fl_rbyte;
    logic        dma_sum;

    // ------------------------------------------------------------------
    // Pin synchronisers.
    // ------------------------------------------------------------------

    // Two flip-flops on every asynchronous pin level.
    always_ff @(posedge i_clk)
    begin
        sync1_q <= {i_flash_jumper, i_fpga_init_pin,
                    i_fpga_done_pin, i_user_fpga_irq};
        sync2_q <= sync1_q;
    end

    assign jumper_s = sync2_q[3];
    assign init_s   = sync2_q[2];
    assign done_s   = sync2_q[1];
    assign user_s   = sync2_q[0];

    // ------------------------------------------------------------------
    // Write decode.
    // ------------------------------------------------------------------

    // Strobes for each register; flash writes are dropped during a busy access.
    assign wr_synth = i_bus.wr && hit(i_bus.addr, `HCIR_OFF_SYNTH);
    assign wr_faddr = i_bus.wr && hit(i_bus.addr, `HCIR_OFF_FADDR)
                      && !fl_busy;
    assign wr_fdata = i_bus.wr && hit(i_bus.addr, `HCIR_OFF_FDATA)
                      && !fl_busy;
    assign wr_cfg   = i_bus.wr && hit(i_bus.addr, `HCIR_OFF_CFG);
    assign rd_cfg   = i_bus.rd && hit(i_bus.addr, `HCIR_OFF_CFG);
    assign rd_stat  = i_bus.rd && hit(i_bus.addr, `HCIR_OFF_STAT);
    assign fl_start = wr_faddr;                       // RL3

    // ------------------------------------------------------------------
    // Flash access sequencer.
    // ------------------------------------------------------------------
    hcir_flash_port u_flash
    (
        .i_clk     (i_clk),
        .i_sys_rst (i_sys_rst),
        .i_start   (fl_start),
        .i_write   (i_bus.wdata[`HCIR_FA_DIR]),
        .i_addr    (i_bus.wdata[23:0]),
        .i_wbyte   (fdata_q),
        .i_dq_i    (i_flash_dq),
        .o_busy    (fl_busy),
        .o_done    (fl_done),
        .o_rbyte   (fl_rbyte),
        .o_pins    (o_flash)
    );

    // ------------------------------------------------------------------
    // Register file next state.
    // ------------------------------------------------------------------

    // Store writes, capture fetched flash bytes, schedule config clocks.
    always_comb
    begin
        synth_d = synth_q;
        faddr_d = faddr_q;
        fdata_d = fdata_q;
        cfg_d   = cfg_q;
        pend_d  = 1'b0;
        cclk_d  = pend_q;                             // RL22
        if (wr_synth)
            synth_d = i_bus.wdata[7:0] & `HCIR_SYNTH_WMASK;  // RL1
        if (wr_faddr)
            faddr_d = i_bus.wdata & `HCIR_FADDR_WMASK;       // RL4
        if (wr_fdata)
            fdata_d = i_bus.wdata[7:0];                      // RL5
        else if (fl_done && !faddr_q[`HCIR_FA_DIR])
            fdata_d = fl_rbyte;                              // RL5
        if (wr_cfg)
        begin
            cfg_d  = i_bus.wdata & `HCIR_CFG_WMASK;          // RL9
            pend_d = i_bus.wdata[`HCIR_CFG_CLK];             // RL10
        end
    end

    // Register the writable state.
    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
        begin
            synth_q <= `HCIR_RST_SYNTH;
            faddr_q <= `HCIR_RST_FADDR;
            fdata_q <= `HCIR_RST_FDATA;
            cfg_q   <= `HCIR_RST_CFG;
            pend_q  <= 1'b0;
            cclk_q  <= 1'b0;
        end
        else
        begin
            synth_q <= synth_d;
            faddr_q <= faddr_d;
            fdata_q <= fdata_d;
            cfg_q   <= cfg_d;
            pend_q  <= pend_d;
            cclk_q  <= cclk_d;
        end
    end

    // ------------------------------------------------------------------
    // Pin outputs.
    // ------------------------------------------------------------------

    // Serial clock and data are shared by all synthesizers.
    assign o_synth_sclk  = synth_q[`HCIR_SS_SCLK];    // RL1
    assign o_synth_sdata = synth_q[`HCIR_SS_SDATA];   // RL1

    // Each load strobe follows its own control bit.
    generate
        for (genvar n = 0; n < `HCIR_SS_NLOAD; n++)
        begin : g_load
            assign o_synth_load[n] = synth_q[`HCIR_SS_LOAD_LSB + n]; // RL2
        end
    endgenerate

    // User FPGA configuration pins and register index.
    assign o_fpga_program_pin  = cfg_q[`HCIR_CFG_FPGA_PROGRAM];   // RL9
    assign o_fpga_init_drive   = cfg_q[`HCIR_CFG_INIT];   // RL9
    assign o_cfg_bit           = cfg_q[`HCIR_CFG_BIT];    // RL10
    assign o_cfg_clk           = cclk_q;                  // RL10
    assign o_user_reg_index    = cfg_q[6:0];              // RL7
    assign o_burst_fifo_enable = cfg_q[`HCIR_CFG_FIFO_EN];

    // ------------------------------------------------------------------
    // Interrupt gathering.
    // ------------------------------------------------------------------

    // Completion counts only while its own enable is set.
    assign dma_sum = (i_sg_done && i_sg_complete_irq_enable)  // RL21
                     || i_page_irq;                           // RL20

    // Host interrupt from gated DMA and user FPGA sources.
    always_comb
    begin
        host_irq_d = cfg_q[`HCIR_CFG_HOST_EN]                 // RL11
                     && (dma_sum                              // RL20
                         || (cfg_q[`HCIR_CFG_USER_EN] && user_s)); // RL19
    end

    // Register the interrupt line.
    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
            host_irq_q <= 1'b0;
        else
            host_irq_q <= host_irq_d;
    end

    assign o_host_irq = host_irq_q;

    // ------------------------------------------------------------------
    // Read path.
    // ------------------------------------------------------------------

    // Select read data; unmapped addresses and idle cycles give zero.
    always_comb
    begin
        rdata_d = 32'h0000_0000;
        if (i_bus.rd)
        begin
            if (hit(i_bus.addr, `HCIR_OFF_SYNTH))
                rdata_d[7:0] = synth_q;
            else if (hit(i_bus.addr, `HCIR_OFF_FADDR))
                rdata_d = faddr_q;
            else if (hit(i_bus.addr, `HCIR_OFF_FDATA))
            begin
                rdata_d[7:0]            = fdata_q;       // RL5
                rdata_d[`HCIR_FD_JUMPER] = jumper_s;     // RL6
            end
            else if (hit(i_bus.addr, `HCIR_OFF_CFG))
            begin
                rdata_d                  = cfg_q;
                rdata_d[`HCIR_CFG_SENSE] = init_s;       // RL8
                rdata_d[`HCIR_CFG_DONE]  = done_s;       // RL9
            end
            else if (hit(i_bus.addr, `HCIR_OFF_STAT))
            begin
                rdata_d[`HCIR_ST_HOST] = host_irq_q;     // RL18
                rdata_d[`HCIR_ST_USER] = user_s;         // RL19
                rdata_d[`HCIR_ST_DMA]  = dma_sum;        // RL20
            end
            else if (hit(i_bus.addr, `HCIR_OFF_FBUSY))
                rdata_d[0] = fl_busy;
        end
    end

    // Read data stand for exactly the cycle after the read strobe.
    always_ff @(posedge i_clk)
    begin
        if (i_sys_rst)
            rdata_q <= 32'h0000_0000;
        else
            rdata_q <= rdata_d;
    end

    assign o_rdata = rdata_q;

    // ------------------------------------------------------------------
    // Checks.
    // ------------------------------------------------------------------

    property p_synth_pins;
        @(posedge i_clk) disable iff (i_sys_rst)
        wr_synth |=> (o_synth_sclk == $past(i_bus.wdata[`HCIR_SS_SCLK]))
            && (o_synth_sdata == $past(i_bus.wdata[`HCIR_SS_SDATA]));
    endproperty
    a_synth_pins: assert property (p_synth_pins) // RL1
        else $error("synth serial pins do not follow write");

    property p_synth_load;
        @(posedge i_clk) disable iff (i_sys_rst)
        wr_synth |=> o_synth_load == $past(i_bus.wdata[3:0]);
    endproperty
    a_synth_load: assert property (p_synth_load) // RL2
        else $error("synth load strobes do not follow write");

    property p_cfg_pulse;
        @(posedge i_clk) disable iff (i_sys_rst)
        (wr_cfg && i_bus.wdata[`HCIR_CFG_CLK]) |=> !o_cfg_clk
            ##1 o_cfg_clk && (o_cfg_bit == $past(i_bus.wdata[16], 2));
    endproperty
    a_cfg_pulse: assert property (p_cfg_pulse) // RL10
        else $error("config clock missing or data wrong");

    property p_cfg_once;
        @(posedge i_clk) disable iff (i_sys_rst)
        o_cfg_clk |-> $past(wr_cfg, 2) && $past(i_bus.wdata[17], 2);
    endproperty
    a_cfg_once: assert property (p_cfg_once) // RL22
        else $error("config clock without its own write");

    property p_sense_read;
        @(posedge i_clk) disable iff (i_sys_rst)
        rd_cfg |=> o_rdata[`HCIR_CFG_SENSE] == $past(init_s);
    endproperty
    a_sense_read: assert property (p_sense_read) // RL8
        else $error("init sense bit wrong on read");

    property p_host_gate;
        @(posedge i_clk) disable iff (i_sys_rst)
        !cfg_q[`HCIR_CFG_HOST_EN] |=> !o_host_irq;
    endproperty
    a_host_gate: assert property (p_host_gate) // RL11
        else $error("host interrupt raised while disabled");

    property p_user_gate;
        @(posedge i_clk) disable iff (i_sys_rst)
        (!dma_sum && !(user_s && cfg_q[`HCIR_CFG_USER_EN]))
            |=> !o_host_irq;
    endproperty
    a_user_gate: assert property (p_user_gate) // RL19
        else $error("user interrupt passed without its enable");

    property p_dma_raise;
        @(posedge i_clk) disable iff (i_sys_rst)
        (dma_sum && cfg_q[`HCIR_CFG_HOST_EN]) |=> o_host_irq;
    endproperty
    a_dma_raise: assert property (p_dma_raise) // RL20
        else $error("DMA interrupt did not raise host interrupt");

    property p_sg_block;
        @(posedge i_clk) disable iff (i_sys_rst)
        (!i_sg_complete_irq_enable && !i_page_irq) |-> !dma_sum;
    endproperty
    a_sg_block: assert property (p_sg_block) // RL21
        else $error("blocked completion reached DMA summary");

    property p_stat_host;
        @(posedge i_clk) disable iff (i_sys_rst)
        rd_stat |=> o_rdata[`HCIR_ST_HOST] == $past(o_host_irq);
    endproperty
    a_stat_host: assert property (p_stat_host) // RL18
        else $error("status does not show host interrupt");

endmodule

// >>> hcir_map.svh
`ifndef HCIR_MAP_SVH
`define HCIR_MAP_SVH
// ----------------------------------------------------------------------
// Summary of operation
// RL1 - Synth control bit 7 drives all serial clocks, bit 6 shared data.
// RL2 - Synth control bits 3..0 drive load strobe of synthesizer n.
// RL3 - Flash address bits 23..0 hold location of next flash access.
// RL4 - Flash address bit 24 picks direction: 1 writes byte, 0 reads.
// RL5 - Flash data bits 7..0 carry byte to write or fetched byte.
// RL6 - Flash data bit 8 reads protection jumper; 1 allows reprogramming.
// RL7 - Config bits 6..0 index one of 128 user FPGA byte registers.
// RL8 - Config bit 21 is read-only sensed level of FPGA init pin.
// RL9 - Config bits 20, 19, 18 serve complete, program and init pins.
// RL10 - Config bit 17 issues one config clock carrying bit 16 as data.
// RL11 - Config bit 15 gates host interrupt; bit 14 gates FPGA interrupt.
// RL12 - Software toggles FPGA interface enable before setting FIFO bit 8.
// RL13 - Software drives program and init low, awaits complete low, raises.
// RL14 - Software polls init sense for 1 then waits four microseconds.
// RL15 - Software sends image one bit per write with clock bit set.
// RL16 - Software clocks ones after image until complete pin reads 1.
// RL17 - Configuration failed if complete not seen within 32 extra clocks.
// RL18 - Status bit 15 reads 1 while the host interrupt is driven.
// RL19 - Status bit 13 shows FPGA interrupt; raises host only with 14, 15.
// RL20 - Status bit 12 ORs DMA interrupts; raises host when bit 15 set.
// RL21 - Scatter-gather completion counts only while its enable is 1.
// RL22 - One config clock per write with bit 17; never repeats alone.
// ----------------------------------------------------------------------

// ----------------------------------------------------------------------
// Register offsets.
// ----------------------------------------------------------------------
`define HCIR_OFF_SYNTH  8'h20
`define HCIR_OFF_FADDR  8'h80
`define HCIR_OFF_FDATA  8'h84
`define HCIR_OFF_CFG    8'hc4
`define HCIR_OFF_STAT   8'hc8
`define HCIR_OFF_FBUSY  8'hd0

// ----------------------------------------------------------------------
// Field positions.
// ----------------------------------------------------------------------
`define HCIR_SS_SCLK      7
`define HCIR_SS_SDATA     6
`define HCIR_SS_LOAD_LSB  0
`define HCIR_SS_NLOAD     4
`define HCIR_FA_DIR       24
`define HCIR_FD_JUMPER    8
`define HCIR_CFG_SENSE    21
`define HCIR_CFG_DONE     20
`define HCIR_CFG_FPGA_PROGRAM     19
`define HCIR_CFG_INIT     18
`define HCIR_CFG_CLK      17
`define HCIR_CFG_BIT      16
`define HCIR_CFG_HOST_EN  15
`define HCIR_CFG_USER_EN  14
`define HCIR_CFG_FIFO_EN  8
`define HCIR_ST_HOST      15
`define HCIR_ST_USER      13
`define HCIR_ST_DMA       12

// ----------------------------------------------------------------------
// Write masks and reset values.
// ----------------------------------------------------------------------
`define HCIR_SYNTH_WMASK  8'hcf
`define HCIR_FADDR_WMASK  32'h01ff_ffff
`define HCIR_CFG_WMASK    32'h000f_c17f
`define HCIR_RST_SYNTH    8'h00
`define HCIR_RST_FADDR    32'h0000_0000
`define HCIR_RST_FDATA    8'h00
`define HCIR_RST_CFG      32'h000c_0000
`define HCIR_RST_PINS     36'h0_0000_0007

// ----------------------------------------------------------------------
// Timing.
// ----------------------------------------------------------------------
`define HCIR_CLK_PERIOD_NS  8
`define HCIR_FLASH_ACC_NS   120
`define HCIR_FLASH_ACC_CYC  \
    ((`HCIR_FLASH_ACC_NS + `HCIR_CLK_PERIOD_NS - 1) / `HCIR_CLK_PERIOD_NS)
`endif

// >>> hcir_pkg.sv
package hcir_pkg;

    // Register port request, one cycle per access.
    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } hcir_bus_req_t;

    // Flash device pins driven by the block.
    typedef struct packed {
        logic [23:0] addr;
        logic [7:0]  dq_o;
        logic        dq_oe;
        logic        ce_n;
        logic        oe_n;
        logic        we_n;
    } hcir_flash_pins_t;

    // Flash access sequencer states, Gray along the access path.
    typedef enum logic [1:0] {
        fl_idle    = 2'b00,
        fl_access  = 2'b01,
        fl_recover = 2'b11
    } hcir_fl_state_t;

endpackage

// >>> hcir_flash_port.sv
`timescale 1ns/1ns
`include "hcir_map.svh"
module hcir_flash_port
(
    input  wire logic                    i_clk,
    input  wire logic                    i_sys_rst,
    input  wire logic                    i_start,
    input  wire logic                    i_write,
    input  wire logic [23:0]             i_addr,
    input  wire logic [7:0]              i_wbyte,
    input  wire logic [7:0]              i_dq_i,
    output logic                         o_busy,
    output logic                         o_done,
    output logic [7:0]                   o_rbyte,
    output hcir_pkg::hcir_flash_pins_t   o_pins
);
    import hcir_pkg::*;

    hcir_fl_state_t   state_q, state_d;
    logic [4:0]       cnt_q, cnt_d;
    hcir_flash_pins_t pins_q, pins_d;
    logic             wr_q, wr_d;
    logic             done_q, done_d;
    logic [7:0]       rbyte_q, rbyte_d;
    logic [7:0]       dq_s1_q, dq_s2_q;

    // Sequence one strobed byte access, then release the bus.
    always_comb
    begin
        state_d = state_q;
        cnt_d   = cnt_q;
        pins_d  = pins_q;
        wr_d    = wr_q;
        done_d  = 1'b0;
        rbyte_d = rbyte_q;
        case (state_q)
            fl_idle:
                if (i_start)
                begin
                    state_d      = fl_access;
                    cnt_d        = 5'(`HCIR_FLASH_ACC_CYC - 1);
                    wr_d         = i_write;
                    pins_d.addr  = i_addr;          // RL3
                    pins_d.dq_o  = i_wbyte;         // RL5
                    pins_d.dq_oe = i_write;         // RL4
                    pins_d.ce_n  = 1'b0;
                    pins_d.oe_n  = i_write;
                    pins_d.we_n  = !i_write;
                end
            fl_access:
                if (cnt_q == 5'h00)
                begin
                    state_d     = fl_recover;
                    pins_d.ce_n = 1'b1;
                    pins_d.oe_n = 1'b1;
                    pins_d.we_n = 1'b1;
                    if (!wr_q)
                        rbyte_d = dq_s2_q;          // RL5
                end
                else
                    cnt_d = cnt_q - 5'h01;
            fl_recover:
            begin
                state_d      = fl_idle;
                pins_d.dq_oe = 1'b0;
                done_d       = 1'b1;
            end
            default:
                state_d = fl_idle;
        endcase
    end

    // Register the sequencer and pass flash data through two flip-flops.
    always_ff @(posedge i_clk)
    begin
        dq_s1_q <= i_dq_i;
        dq_s2_q <= dq_s1_q;
        if (i_sys_rst)
        begin
            state_q <= fl_idle;
            cnt_q   <= 5'h00;
            pins_q  <= hcir_flash_pins_t'(`HCIR_RST_PINS);
            wr_q    <= 1'b0;
            done_q  <= 1'b0;
            rbyte_q <= 8'h00;
        end
        else
        begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
            pins_q  <= pins_d;
            wr_q    <= wr_d;
            done_q  <= done_d;
            rbyte_q <= rbyte_d;
        end
    end

    assign o_busy  = (state_q != fl_idle);
    assign o_done  = done_q;
    assign o_rbyte = rbyte_q;
    assign o_pins  = pins_q;

    property p_flash_dir;
        @(posedge i_clk) disable iff (i_sys_rst)
        (i_start && !o_busy) |=> (o_pins.we_n == !$past(i_write))
            && (o_pins.oe_n == $past(i_write))
            && (o_pins.addr == $past(i_addr));
    endproperty
    a_flash_dir: assert property (p_flash_dir) // RL4
        else $error("flash strobe or address does not follow request");

    property p_flash_len;
        @(posedge i_clk) disable iff (i_sys_rst)
        (i_start && !o_busy) |=> !o_pins.ce_n [*8] ##[1:20] o_done;
    endproperty
    a_flash_len: assert property (p_flash_len) // RL3
        else $error("flash access too short or never finished");

endmodule

// >>> hcir_far_model.sv
`timescale 1ns/1ns
module hcir_far_model
(
    input  wire logic                       i_clk,
    input  wire hcir_pkg::hcir_flash_pins_t i_flash,
    output logic [7:0]                      o_flash_dq,
    input  wire logic                       i_fpga_program_pin,
    input  wire logic                       i_fpga_init_drive,
    input  wire logic                       i_cfg_clk,
    input  wire logic                       i_cfg_bit,
    output logic                            o_fpga_init_pin,
    output logic                            o_fpga_done_pin
);
    import hcir_pkg::*;
    localparam int DONE_ONES = 3;
    logic [7:0] mem [16];
    logic [7:0] last_q = 8'h00;
    int         ones = 0;
    logic       rd_on;
    assign rd_on = !i_flash.ce_n && !i_flash.oe_n;
    // Flash array stores while we_n is low and remembers the last byte read.
    always @(posedge i_clk)
    begin
        if (!i_flash.ce_n && !i_flash.we_n && i_flash.dq_oe)
            mem[i_flash.addr[3:0]] <= i_flash.dq_o;
        if (rd_on)
            last_q <= mem[i_flash.addr[3:0]];
    end
    // A released data bus shows the inverse of the last byte, not a copy.
    assign o_flash_dq = rd_on ? mem[i_flash.addr[3:0]] : ~last_q;
    // Init follows the drive once program is high; done after enough ones.
    assign o_fpga_init_pin = i_fpga_program_pin
                             & i_fpga_init_drive;
    assign o_fpga_done_pin = i_fpga_program_pin
                             && ones >= DONE_ONES;
    always @(posedge i_clk)
    begin
        if (!i_fpga_program_pin)
            ones <= 0;
        else if (i_cfg_clk && i_cfg_bit)
            ones <= ones + 1;
    end
endmodule

// >>> hcir_regs_bench.sv
`timescale 1ns/1ns
module hcir_regs_bench;
    import hcir_pkg::*;
    logic             clk = 1'b0;
    logic             rst = 1'b1;
    hcir_bus_req_t    bus = '0;
    hcir_flash_pins_t fl;
    logic [31:0]      rdata, v;
    logic [7:0]       dq;
    logic [6:0]       idx;
    logic [3:0]       load;
    logic             sclk, sdata, pgm, ini, ipin, dpin, cclk, cbit, fifo;
    logic             uirq = 1'b0, sgd = 1'b0, sge = 1'b0, pgi = 1'b0, hirq;
    logic             jmp = 1'b1;
    int               mismatches = 0, num_checks = 0, cycles = 0, pulses = 0;
    hcir_regs u_hcir_regs (.i_clk(clk), .i_sys_rst(rst), .i_bus(bus),
        .o_rdata(rdata), .o_synth_sclk(sclk), .o_synth_sdata(sdata),
        .o_synth_load(load), .o_flash(fl), .i_flash_dq(dq),
        .i_flash_jumper(jmp), .o_fpga_program_pin(pgm),
        .o_fpga_init_drive(ini), .i_fpga_init_pin(ipin),
        .i_fpga_done_pin(dpin), .o_cfg_clk(cclk), .o_cfg_bit(cbit),
        .o_user_reg_index(idx), .o_burst_fifo_enable(fifo),
        .i_user_fpga_irq(uirq), .i_sg_done(sgd),
        .i_sg_complete_irq_enable(sge), .i_page_irq(pgi), .o_host_irq(hirq));
    hcir_far_model u_hcir_far_model (.i_clk(clk), .i_flash(fl),
        .o_flash_dq(dq), .i_fpga_program_pin(pgm), .i_fpga_init_drive(ini),
        .i_cfg_clk(cclk), .i_cfg_bit(cbit), .o_fpga_init_pin(ipin),
        .o_fpga_done_pin(dpin));
    // Clock, pulse counter and hang guard.
    initial
    begin
        forever #4 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cycles++;
        if (cclk === 1'b1)
            pulses++;
        if (cycles == 5000)
        begin
            mismatches++;
            finish_test();
        end
    end
    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic chk(input string w, input logic [31:0] e,
                       input logic [31:0] g);
        num_checks++;
        if (g !== e)
        begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", w, e, g);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus.wr <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus.rd <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic t_synth();
        wr(8'h20, 32'hc5);
        cyc(1);
        chk("synth_pins", 32'h35, {26'h0, sclk, sdata, load});
        wr(8'h20, 32'h4a);
        cyc(1);
        chk("synth_pins", 32'h1a, {26'h0, sclk, sdata, load});
        rd(8'h20, v);
        chk("synth_read", 32'h4a, v);
        rd(8'h44, v);
        chk("unmapped", 32'h0, v);
        $display("test synth done");
    endtask
    task automatic idle_wait();
        for (int n = 0; n < 40; n++)
        begin
            rd(8'hd0, v);
            if (v[0] === 1'b0)
                break;
        end
        chk("flash_idle", 32'h0, {31'h0, v[0]});
    endtask
    task automatic t_flash();
        wr(8'h84, 32'h5a);
        wr(8'h80, 32'h0100_0012);
        cyc(1);
        chk("flash_addr", 32'h12, {8'h0, fl.addr});
        chk("flash_we_n", 32'h0, {31'h0, fl.we_n});
        chk("flash_dq_o", 32'h5a, {24'h0, fl.dq_o});
        idle_wait();
        wr(8'h84, 32'ha5);
        wr(8'h80, 32'h0000_0012);
        cyc(1);
        chk("flash_oe_n", 32'h0, {31'h0, fl.oe_n});
        idle_wait();
        rd(8'h84, v);
        chk("flash_data", 32'h15a, v);
        rd(8'h80, v);
        chk("faddr_rd", 32'h12, v);
        @(posedge clk) jmp <= 1'b0;
        cyc(2);
        rd(8'h84, v);
        chk("jumper", 32'h5a, v);
        $display("test flash done");
    endtask
    task automatic t_cfg();
        wr(8'hc4, 32'h0);
        cyc(3);
        rd(8'hc4, v);
        chk("cfg_low", 32'h0, {30'h0, v[21:20]});
        chk("pins_low", 32'h0, {30'h0, pgm, ini});
        wr(8'hc4, 32'h000c_0055);
        cyc(3);
        rd(8'hc4, v);
        chk("init_sense", 32'h1, {31'h0, v[21]});
        chk("index", 32'h55, {25'h0, idx});
        cyc(500);
        pulses = 0;
        wr(8'hc4, 32'h000f_0055);
        wr(8'hc4, 32'h000f_0055);
        cyc(6);
        chk("pulses", 32'h2, pulses);
        chk("cfg_bit", 32'h1, {31'h0, cbit});
        wr(8'hc4, 32'h000f_0155);
        cyc(4);
        rd(8'hc4, v);
        chk("done", 32'h1, {31'h0, v[20]});
        chk("fifo_en", 32'h1, {31'h0, fifo});
        $display("test cfg done");
    endtask
    task automatic t_irq();
        @(posedge clk) pgi <= 1'b1;
        cyc(2);
        chk("irq_gated", 32'h0, {31'h0, hirq});
        wr(8'hc4, 32'h000c_8000);
        cyc(2);
        chk("irq_dma", 32'h1, {31'h0, hirq});
        rd(8'hc8, v);
        chk("status", 32'h9000, v);
        @(posedge clk) {pgi, sgd} <= 2'b01;
        cyc(2);
        chk("irq_sg_off", 32'h0, {31'h0, hirq});
        @(posedge clk) sge <= 1'b1;
        cyc(2);
        chk("irq_sg_on", 32'h1, {31'h0, hirq});
        @(posedge clk) {sgd, uirq} <= 2'b01;
        cyc(5);
        chk("irq_user_off", 32'h0, {31'h0, hirq});
        rd(8'hc8, v);
        chk("status", 32'h2000, v);
        wr(8'hc4, 32'h000c_c000);
        cyc(2);
        chk("irq_user_on", 32'h1, {31'h0, hirq});
        $display("test irq done");
    endtask
    initial
    begin
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        cyc(2);
        t_synth();
        t_flash();
        t_cfg();
        t_irq();
        finish_test();
    end
endmodule
